// >>> design/clock_watch_defs.svh
// Offsets, field positions, reset values and timing counts of the clock
// watch status block. Included by the package user files; definitions only.
`ifndef CLOCK_WATCH_DEFS_SVH
`define CLOCK_WATCH_DEFS_SVH
`define CW_OFF_CTRL 8'h00
`define CW_OFF_FLAGS 8'h04
`define CW_OFF_STATUS 8'h08
`define CW_BIT_LOCK_IE 0
`define CW_BIT_SC_IE 1
`define CW_BIT_SC_ALLOW 2
`define CW_BIT_WATCH_EN 3
`define CW_BIT_LOCK_FLAG 0
`define CW_BIT_SC_FLAG 1
`define CW_BIT_ST_LOCK 0
`define CW_BIT_ST_SC 1
`define CW_BIT_ST_OSC_SEL 2
`define CW_BIT_ST_WATCH_FAIL 3
`define CW_BIT_ST_QC_BUSY 4
`define CW_CTRL_RESET 4'hc
`define CW_QC_WINDOWS 50
`define CW_WATCH_DELAY_NS 1000
`define CW_CLK_PERIOD_NS 4
`define CW_WATCH_CYCLES (`CW_WATCH_DELAY_NS / `CW_CLK_PERIOD_NS)
`endif

// >>> design/clock_watch_pkg.sv
// Types shared by the clock watch status block.
// Assumes the defines header is included by the design file.
package clock_watch_pkg;
  typedef enum logic [2:0]
  {
    QC_IDLE = 3'b001,
    QC_RUN = 3'b010,
    QC_DONE = 3'b100
  } qc_state_e;
  typedef logic [31:0] word_t;
endpackage

// >>> design/clock_monitor_status_irq.sv
// Status, interrupt and clock watch logic of a clock and reset generator.
// Assumes an AHB-Lite master, a synchronous osc_ref_clock sample and a
// clock quality result supplied by the analog checker.
//
// Overview of operation
// R1 - Lock-change flag sets on every change of PLL lock state.
// R2 - Lock-change flag clears only on software writing one.
// R3 - Lock interrupt request blocked while its enable is zero.
// R4 - Self-clock change flag sets on entering and leaving self-clock mode.
// R5 - Self-clock condition may change only while self-clock allow is one; a watch reset also sets it while allow is zero.
// R6 - Failed quality check after resets or stop recovery enters self-clock.
// R7 - With watch enabled and allow set, reference loss enters self-clock.
// R8 - Self-clock interrupt request blocked while its enable is zero.
// R9 - Self-clock change flag clears only on software writing one.
// R10 - Oscillator type select is latched at reset release and held.
// R11 - Latched zero picks low-power oscillator, one picks full swing.
// R12 - Buffered crystal input serves as the internal reference clock.
// R13 - Missing reference edge in window fails; self-clock or reset follows.
// R14 - No failure while watch is disabled or edges keep arriving.
// R15 - Watch delay runs apart from device clocks, seeing stopped references.
// R16 - Watch reset sets enable and allow, enters self-clock, starts reset.
// R17 - Stop recovery runs up to 50 check windows, then falls back.
// R18 - Each interrupt is flag AND enable, held until cleared.
`include "clock_watch_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module clock_monitor_status_irq
  import clock_watch_pkg::*;
#(
  parameter int WATCH_CYCLES = `CW_WATCH_CYCLES,
  parameter int QC_WINDOWS = `CW_QC_WINDOWS
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pll_lock,
  input wire logic osc_type_select,
  input wire logic crystal_in,
  input wire logic qc_start,
  input wire logic qc_window_end,
  input wire logic qc_window_ok,
  output logic osc_ref_clock,
  output logic osc_low_power_sel,
  output logic self_clock_condition,
  output logic watch_reset_req,
  output logic lock_irq,
  output logic self_clock_irq
);

  logic lock_irq_enable;
  logic self_clock_irq_enable;
  logic self_clock_allow;
  logic clock_watch_enable;
  logic lock_change_flag;
  logic self_clock_change_flag;
  logic osc_sel_r;
  logic reset_seen_r;
  logic lock_prev_r;
  logic ref_prev_r;
  logic watch_fail_r;
  logic [31:0] watch_cnt_r;
  logic [6:0] qc_cnt_r;
  qc_state_e qc_state_r;
  logic qc_fail;
  logic sc_enter;
  logic sc_leave;
  logic sc_prev_r;
  logic ph_valid_r;
  logic ph_write_r;
  logic [7:0] ph_addr_r;
  logic wr_ctrl;
  logic wr_flags;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // AHB-Lite slave: zero wait states, always OKAY, unmapped reads as zero.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ph_valid_r <= 1'b0;
      ph_write_r <= 1'b0;
      ph_addr_r <= 8'h00;
    end
    else if (hready)
    begin
      ph_valid_r <= hsel && htrans[1];
      ph_write_r <= hwrite;
      ph_addr_r <= haddr[7:0];
    end
  end

  assign wr_ctrl = ph_valid_r && ph_write_r && hit(ph_addr_r, `CW_OFF_CTRL);
  assign wr_flags = ph_valid_r && ph_write_r
    && hit(ph_addr_r, `CW_OFF_FLAGS);

  // A monitor reset reloads allow and enable as well as the other bits.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lock_irq_enable <= 1'b0;
      self_clock_irq_enable <= 1'b0;
      self_clock_allow <= 1'b1;
      clock_watch_enable <= 1'b1;
    end
    else if (watch_reset_req)
    begin
      lock_irq_enable <= 1'b0;
      self_clock_irq_enable <= 1'b0;
      self_clock_allow <= 1'b1; // [R16]
      clock_watch_enable <= 1'b1; // [R16]
    end
    else if (wr_ctrl)
    begin
      lock_irq_enable <= hwdata[`CW_BIT_LOCK_IE];
      self_clock_irq_enable <= hwdata[`CW_BIT_SC_IE];
      self_clock_allow <= hwdata[`CW_BIT_SC_ALLOW];
      clock_watch_enable <= hwdata[`CW_BIT_WATCH_EN];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      hrdata <= 32'h0000_0000;
      if (hit(haddr[7:0], `CW_OFF_CTRL))
      begin
        hrdata[`CW_BIT_LOCK_IE] <= lock_irq_enable;
        hrdata[`CW_BIT_SC_IE] <= self_clock_irq_enable;
        hrdata[`CW_BIT_SC_ALLOW] <= self_clock_allow;
        hrdata[`CW_BIT_WATCH_EN] <= clock_watch_enable;
      end
      else if (hit(haddr[7:0], `CW_OFF_FLAGS))
      begin
        hrdata[`CW_BIT_LOCK_FLAG] <= lock_change_flag;
        hrdata[`CW_BIT_SC_FLAG] <= self_clock_change_flag;
      end
      else if (hit(haddr[7:0], `CW_OFF_STATUS))
      begin
        hrdata[`CW_BIT_ST_LOCK] <= lock_prev_r;
        hrdata[`CW_BIT_ST_SC] <= self_clock_condition;
        hrdata[`CW_BIT_ST_OSC_SEL] <= osc_sel_r;
        hrdata[`CW_BIT_ST_WATCH_FAIL] <= watch_fail_r;
        hrdata[`CW_BIT_ST_QC_BUSY] <= (qc_state_r == QC_RUN);
      end
    end
  end

  // The strap is caught on the first clock after reset release.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reset_seen_r <= 1'b0;
      osc_sel_r <= 1'b0;
    end
    else if (!reset_seen_r)
    begin
      reset_seen_r <= 1'b1;
      osc_sel_r <= osc_type_select; // [R10]
    end
  end

  assign osc_low_power_sel = !osc_sel_r; // [R11]

  // The reference is passed through as a buffered copy of the crystal pin.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      osc_ref_clock <= 1'b0;
    end
    else
    begin
      osc_ref_clock <= crystal_in; // [R12]
    end
  end

  // The delay counter stands for the analog timer, so it does not depend on
  // the derived reference; a gated system clock would defeat it.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ref_prev_r <= 1'b0;
      watch_cnt_r <= 32'h0000_0000;
      watch_fail_r <= 1'b0;
    end
    else
    begin
      ref_prev_r <= osc_ref_clock;
      if (!clock_watch_enable || (osc_ref_clock != ref_prev_r))
      begin
        watch_cnt_r <= 32'h0000_0000; // [R14] [R15]
        watch_fail_r <= 1'b0; // [R14]
      end
      else if (watch_cnt_r >= 32'(WATCH_CYCLES - 1))
      begin
        watch_fail_r <= 1'b1; // [R13]
      end
      else
      begin
        watch_cnt_r <= watch_cnt_r + 32'h0000_0001;
      end
    end
  end

  // Quality check: up to QC_WINDOWS windows, stopping at the first good one.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      qc_state_r <= QC_IDLE;
      qc_cnt_r <= 7'h00;
    end
    else
    begin
      case (qc_state_r)
        QC_IDLE:
        begin
          if (qc_start)
          begin
            qc_state_r <= QC_RUN;
            qc_cnt_r <= 7'h00;
          end
        end
        QC_RUN:
        begin
          if (qc_window_end)
          begin
            if (qc_window_ok || (qc_cnt_r == 7'(QC_WINDOWS - 1))) // [R17]
            begin
              qc_state_r <= QC_DONE;
            end
            qc_cnt_r <= qc_cnt_r + 7'h01;
          end
        end
        QC_DONE:
        begin
          qc_state_r <= QC_IDLE;
        end
        default:
        begin
          qc_state_r <= QC_IDLE;
        end
      endcase
    end
  end

  assign qc_fail = (qc_state_r == QC_RUN) && qc_window_end && !qc_window_ok
    && (qc_cnt_r == 7'(QC_WINDOWS - 1));

  // The failure paths either enter self-clock or ask for a monitor reset.
  assign sc_enter = self_clock_allow
    && (qc_fail || (watch_fail_r && clock_watch_enable)); // [R6] [R7]
  assign sc_leave = self_clock_allow && (qc_state_r == QC_RUN)
    && qc_window_end && qc_window_ok && !watch_fail_r;
  assign watch_reset_req = !self_clock_allow
    && ((watch_fail_r && clock_watch_enable) || qc_fail); // [R13] [R17]

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      self_clock_condition <= 1'b0;
    end
    else if (watch_reset_req)
    begin
      self_clock_condition <= 1'b1; // [R16]
    end
    else if (sc_enter)
    begin
      self_clock_condition <= 1'b1; // [R5] [R6]
    end
    else if (sc_leave)
    begin
      self_clock_condition <= 1'b0; // [R5]
    end
  end

  // Setting beats the software clear so that no change event is lost.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lock_prev_r <= 1'b0;
      sc_prev_r <= 1'b0;
      lock_change_flag <= 1'b0;
      self_clock_change_flag <= 1'b0;
    end
    else
    begin
      lock_prev_r <= pll_lock;
      sc_prev_r <= self_clock_condition;
      if (pll_lock != lock_prev_r)
      begin
        lock_change_flag <= 1'b1; // [R1]
      end
      else if (wr_flags && hwdata[`CW_BIT_LOCK_FLAG])
      begin
        lock_change_flag <= 1'b0; // [R2]
      end
      if (self_clock_condition != sc_prev_r)
      begin
        self_clock_change_flag <= 1'b1; // [R4]
      end
      else if (wr_flags && hwdata[`CW_BIT_SC_FLAG])
      begin
        self_clock_change_flag <= 1'b0; // [R9]
      end
    end
  end

  assign lock_irq = lock_change_flag && lock_irq_enable; // [R3] [R18]
  assign self_clock_irq = self_clock_change_flag
    && self_clock_irq_enable; // [R8] [R18]

  property p_lock_set;
    @(posedge clk_sys) disable iff (!reset_n)
    (pll_lock != lock_prev_r) |=> lock_change_flag;
  endproperty
  a_lock_set: assert property (p_lock_set) // [R1]
    else $error("lock change flag not set after lock change");

  property p_lock_hold;
    @(posedge clk_sys) disable iff (!reset_n)
    lock_change_flag && !(wr_flags && hwdata[`CW_BIT_LOCK_FLAG])
      |=> lock_change_flag;
  endproperty
  a_lock_hold: assert property (p_lock_hold) // [R2]
    else $error("lock change flag cleared without a write of one");

  property p_lock_irq;
    @(posedge clk_sys) disable iff (!reset_n)
    !lock_irq_enable |-> !lock_irq;
  endproperty
  a_lock_irq: assert property (p_lock_irq) // [R3]
    else $error("lock interrupt raised while disabled");

  property p_sc_set;
    @(posedge clk_sys) disable iff (!reset_n)
    $changed(self_clock_condition) |=> self_clock_change_flag;
  endproperty
  a_sc_set: assert property (p_sc_set) // [R4]
    else $error("self clock flag not set after mode change");

  property p_sc_gate;
    @(posedge clk_sys) disable iff (!reset_n)
    (!self_clock_allow && !watch_reset_req)
      |=> $stable(self_clock_condition);
  endproperty
  a_sc_gate: assert property (p_sc_gate) // [R5]
    else $error("self clock mode changed while not allowed");

  property p_watch_sc;
    @(posedge clk_sys) disable iff (!reset_n)
    (watch_fail_r && clock_watch_enable && self_clock_allow)
      |=> self_clock_condition;
  endproperty
  a_watch_sc: assert property (p_watch_sc) // [R7]
    else $error("reference loss did not enter self clock mode");

  property p_sc_irq;
    @(posedge clk_sys) disable iff (!reset_n)
    self_clock_irq == (self_clock_change_flag && self_clock_irq_enable);
  endproperty
  a_sc_irq: assert property (p_sc_irq) // [R8]
    else $error("self clock interrupt wrong");

  property p_watch_quiet;
    @(posedge clk_sys) disable iff (!reset_n)
    !clock_watch_enable |=> !watch_fail_r;
  endproperty
  a_watch_quiet: assert property (p_watch_quiet) // [R14]
    else $error("watch failure while disabled");

  property p_watch_rst;
    @(posedge clk_sys) disable iff (!reset_n)
    watch_reset_req |=> self_clock_allow && clock_watch_enable
      && self_clock_condition;
  endproperty
  a_watch_rst: assert property (p_watch_rst) // [R16]
    else $error("monitor reset did not restore allow and enable");

endmodule
`default_nettype wire

// >>> verification/crystal_src.sv
// Crystal or external clock source that feeds the reference input.
// Assumes the bench gates it with run; a stopped source holds its last level.
`timescale 1ns/10ps
`default_nettype none
module crystal_src
(
  input wire logic clk_sys,
  input wire logic run,
  output logic crystal_in
);
  logic ph_r = 1'b0;
  logic level_r = 1'b0;
  // One driver for the pin; the level lives in a variable of its own.
  assign crystal_in = level_r;
  // A live source edges every second cycle, well inside the watch window.
  always @(posedge clk_sys)
  begin
    ph_r <= ~ph_r;
    if (run && ph_r)
      level_r <= ~level_r;
  end
endmodule
`default_nettype wire

// >>> verification/clock_monitor_status_irq_bench.sv
// Self-checking bench of the clock watch status block.
// Assumes a zero-wait AHB-Lite slave and short watch and check counts.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) \
  begin \
    samples_checked++; \
    if ((a) !== (b)) \
    begin \
      err_count++; \
      $display("FAIL t=%0t got=%h exp=%h", $time, a, b); \
    end \
  end
module clock_monitor_status_irq_bench;
  import clock_watch_pkg::*;
  localparam int WC = 8;
  localparam int QW = 4;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic pll_lock = 1'b0;
  logic osc_type_select = 1'b1;
  logic qc_start = 1'b0;
  logic qc_window_end = 1'b0;
  logic qc_window_ok = 1'b0;
  logic run = 1'b1;
  logic seen;
  wire logic hready;
  wire logic crystal_in;
  logic [31:0] hrdata;
  logic hresp, osc_ref_clock, osc_low_power_sel, self_clock_condition;
  logic watch_reset_req, lock_irq, self_clock_irq;
  int err_count = 0;
  int samples_checked = 0;
  word_t r;
  word_t rows [6][3] = '{'{32'h0, 32'hf, 32'hf}, '{32'h0, 32'h3, 32'h3},
    '{32'h0, 32'hc, 32'hc}, '{32'hc, 32'hff, 32'h0},
    '{32'h8, 32'hffffffff, 32'h4}, '{32'h4, 32'h0, 32'h0}};
  always #2 clk_sys = ~clk_sys;
  crystal_src i_crystal_src (.clk_sys(clk_sys), .run(run),
    .crystal_in(crystal_in));
  clock_monitor_status_irq #(.WATCH_CYCLES(WC), .QC_WINDOWS(QW))
    i_clock_monitor_status_irq (.clk_sys(clk_sys), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .pll_lock(pll_lock),
    .osc_type_select(osc_type_select), .crystal_in(crystal_in),
    .qc_start(qc_start), .qc_window_end(qc_window_end),
    .qc_window_ok(qc_window_ok), .osc_ref_clock(osc_ref_clock),
    .osc_low_power_sel(osc_low_power_sel),
    .self_clock_condition(self_clock_condition),
    .watch_reset_req(watch_reset_req), .lock_irq(lock_irq),
    .self_clock_irq(self_clock_irq));
  task automatic bus(input logic w, input word_t a, input word_t d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic qc(input logic s, input logic ok);
    @(posedge clk_sys);
    qc_start <= s;
    qc_window_end <= ~s;
    qc_window_ok <= ok;
    @(posedge clk_sys);
    qc_start <= 1'b0;
    qc_window_end <= 1'b0;
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    final_report();
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    cyc(2);
    `CHK(osc_low_power_sel, 1'b0)
    @(posedge clk_sys);
    osc_type_select <= 1'b0;
    cyc(3);
    `CHK(osc_low_power_sel, 1'b0)
    @(negedge clk_sys);
    seen = crystal_in;
    @(negedge clk_sys);
    `CHK(osc_ref_clock, seen)
    bus(0, 32'h0, 32'h0);
    `CHK(r, 32'hc)
    `CHK(hresp, 1'b0)
    foreach (rows[i])
    begin
      bus(1, rows[i][0], rows[i][1]);
      bus(0, rows[i][0], 32'h0);
      `CHK(r, rows[i][2])
    end
    $display("register table done");
    bus(1, 32'h0, 32'h0);
    @(posedge clk_sys);
    pll_lock <= 1'b1;
    cyc(3);
    `CHK(lock_irq, 1'b0)
    bus(1, 32'h4, 32'h0);
    bus(0, 32'h4, 32'h0);
    `CHK(r[0], 1'b1)
    bus(1, 32'h0, 32'h1);
    cyc(1);
    `CHK(lock_irq, 1'b1)
    bus(1, 32'h4, 32'h1);
    cyc(1);
    `CHK(lock_irq, 1'b0)
    @(posedge clk_sys);
    pll_lock <= 1'b0;
    cyc(3);
    `CHK(lock_irq, 1'b1)
    bus(1, 32'h4, 32'h1);
    $display("lock flag done");
    bus(1, 32'h0, 32'he);
    run <= 1'b0;
    cyc(WC + 6);
    `CHK(self_clock_condition, 1'b1)
    `CHK(self_clock_irq, 1'b1)
    bus(1, 32'h0, 32'hc);
    cyc(1);
    `CHK(self_clock_irq, 1'b0)
    bus(1, 32'h4, 32'h2);
    run <= 1'b1;
    // Let the watch see edges again before allow drops, or it resets us.
    cyc(6);
    bus(1, 32'h0, 32'h8);
    cyc(10);
    qc(1, 0);
    qc(0, 1);
    cyc(2);
    `CHK(self_clock_condition, 1'b1)
    bus(1, 32'h0, 32'hc);
    qc(1, 0);
    qc(0, 1);
    cyc(2);
    `CHK(self_clock_condition, 1'b0)
    bus(0, 32'h4, 32'h0);
    `CHK(r[1], 1'b1)
    bus(1, 32'h4, 32'h0);
    bus(0, 32'h4, 32'h0);
    `CHK(r[1], 1'b1)
    bus(1, 32'h4, 32'h2);
    $display("self clock done");
    qc(1, 0);
    repeat (QW - 1) qc(0, 0);
    cyc(2);
    `CHK(self_clock_condition, 1'b0)
    qc(0, 0);
    cyc(2);
    `CHK(self_clock_condition, 1'b1)
    qc(1, 0);
    qc(0, 1);
    $display("quality check done");
    bus(1, 32'h0, 32'h4);
    run <= 1'b0;
    cyc(WC + 6);
    `CHK(self_clock_condition, 1'b0)
    `CHK(watch_reset_req, 1'b0)
    bus(1, 32'h0, 32'h8);
    seen = 1'b0;
    repeat (40) @(negedge clk_sys) seen |= (watch_reset_req === 1'b1);
    `CHK(seen, 1'b1)
    `CHK(self_clock_condition, 1'b1)
    @(posedge clk_sys);
    run <= 1'b1;
    bus(0, 32'h0, 32'h0);
    `CHK(r, 32'hc)
    $display("watch reset done");
    @(posedge clk_sys);
    reset_n <= 1'b0;
    osc_type_select <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    cyc(2);
    `CHK(osc_low_power_sel, 1'b1)
    `CHK(self_clock_condition, 1'b0)
    bus(0, 32'h8, 32'h0);
    `CHK(r, 32'h0)
    $display("second reset done");
    final_report();
  end
endmodule
`default_nettype wire
